// [hw/fius_top.sv]
// fifo, interrupt flags and host clock output of the reader
`timescale 1ns/100ps
`default_nettype none
module fius_top #(
    parameter int TX_CNT_W = 13
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic ss_n_i,
    input wire logic spi_byte_valid_i,
    input wire logic [7:0] spi_byte_i,
    input wire logic spi_rd_req_i,
    input wire logic spi_rd_done_i,
    output logic [7:0] spi_rd_data_o,
    input wire logic tx_active_i,
    input wire logic tx_start_i,
    input wire logic [TX_CNT_W-1:0] tx_total_i,
    input wire logic fr_tx_req_i,
    output logic [7:0] fr_tx_data_o,
    input wire logic rx_active_i,
    input wire logic rx_start_i,
    input wire logic fr_rx_valid_i,
    input wire logic [7:0] fr_rx_data_i,
    input wire logic rx_end_i,
    input wire logic rx_incomplete_i,
    input wire logic [2:0] rx_valid_bits_i,
    input wire logic rx_parity_i,
    input wire logic [7:0] main_evt_i,
    input wire logic [7:0] timer_evt_i,
    input wire logic [7:0] err_evt_i,
    input wire logic osc_run_i,
    input wire logic xtal_ref_i,
    input wire logic lf_clk_i,
    output logic irq_o,
    output logic mcu_clk_o
);
    import fius_pkg::*;

    typedef struct packed {
        fius_mode_t mode;
        logic [5:0] addr;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [6:0] cnt;
        logic [TX_CNT_W-1:0] loaded;
        logic [7:0] irq_main;
        logic [7:0] irq_tim;
        logic [7:0] irq_err;
        logic [7:0] msk_main;
        logic [7:0] msk_tim;
        logic [7:0] msk_err;
        logic [7:0] io_cfg;
        logic lb_incomplete;
        logic [2:0] last_byte_valid_bits;
        logic last_byte_parity_flag;
        logic ovf;
        logic unf;
        logic [7:0] rd_data;
        logic [7:0] tx_data;
        logic irq;
    } fius_state_t;

    fius_state_t q, d;
    logic [7:0] mem_q [FIFO_DEPTH];
    logic mem_we;
    logic [PTR_W-1:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic wr_req, push, pop, water_evt, fifo_busy, all_loaded;
    logic host_wr, host_rd, host_done;
    logic [6:0] wl;
    logic [7:0] head;

    // =========================================================
    // helpers
    function automatic logic [PTR_W-1:0] next_ptr(
        input logic [PTR_W-1:0] p);
        next_ptr = (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + 7'h01;
    endfunction

    function automatic logic pend(input fius_state_t s);
        pend = (|(s.irq_main & ~s.msk_main & ~PTR_MASK)) |
               (|(s.irq_tim & ~s.msk_tim)) | (|(s.irq_err & ~s.msk_err));
    endfunction

    function automatic logic [7:0] status2(input fius_state_t s);
        status2 = 8'h00;
        status2[ST2_INCOMPLETE] = s.lb_incomplete;
        status2[ST2_UNF] = s.unf;
        status2[ST2_OVF] = s.ovf;
        status2[ST2_BITS_LSB +: 3] = s.last_byte_valid_bits;
        status2[ST2_PAR] = s.last_byte_parity_flag;
    endfunction

    assign head = mem_q[q.rd_ptr];
    assign fifo_busy = (q.mode == FIUS_FLOAD) || (q.mode == FIUS_FREAD);
    assign host_wr = !ss_n_i && spi_byte_valid_i;
    assign host_rd = !ss_n_i && spi_rd_req_i;
    assign host_done = !ss_n_i && spi_rd_done_i;
    assign all_loaded = q.loaded >= tx_total_i;

    // =========================================================
    // next state
    always_comb begin
        d = q;
        mem_we = 1'b0;
        mem_waddr = q.wr_ptr;
        mem_wdata = 8'h00;
        wr_req = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        water_evt = 1'b0;
        if (tx_active_i) begin
            wl = q.io_cfg[CFG_TX_WL] ? TX_WL_1 : TX_WL_0;
        end else begin
            wl = q.io_cfg[CFG_RX_WL] ? RX_WL_1 : RX_WL_0;
        end
        // command decode, select high ends every access
        if (ss_n_i) begin
            d.mode = FIUS_CMD;
        end else if (host_wr) begin
            case (q.mode)
                FIUS_CMD: begin
                    d.addr = spi_byte_i[5:0];
                    case (spi_byte_i[7:6])
                        SPI_REG_WR: d.mode = FIUS_WR;
                        SPI_REG_RD: d.mode = FIUS_RD;
                        SPI_FIFO: begin
                            if (spi_byte_i[5:0] == FIFO_LOAD_LOW) begin
                                d.mode = FIUS_FLOAD;
                            end else if (spi_byte_i[5:0] == FIFO_READ_LOW) begin
                                d.mode = FIUS_FREAD;
                            end else begin
                                d.mode = FIUS_SKIP;
                            end
                        end
                        default: d.mode = FIUS_CMD;
                    endcase
                end
                FIUS_WR: begin
                    case (q.addr)
                        ADDR_IO_CFG1: d.io_cfg = spi_byte_i;
                        ADDR_MASK_MAIN: d.msk_main = spi_byte_i;
                        ADDR_MASK_TIM: d.msk_tim = spi_byte_i;
                        ADDR_MASK_ERR: d.msk_err = spi_byte_i;
                        default: ;
                    endcase
                    d.addr = q.addr + 6'h01;
                end
                default: ;
            endcase
        end
        // register read with clear on read
        if (host_rd && q.mode == FIUS_RD) begin
            d.addr = q.addr + 6'h01;
            case (q.addr)
                ADDR_IO_CFG1: d.rd_data = q.io_cfg;
                ADDR_MASK_MAIN: d.rd_data = q.msk_main;
                ADDR_MASK_TIM: d.rd_data = q.msk_tim;
                ADDR_MASK_ERR: d.rd_data = q.msk_err;
                ADDR_IRQ_MAIN: begin
                    d.rd_data = q.irq_main;
                    d.irq_main = q.irq_main & PTR_MASK;
                end
                ADDR_IRQ_TIM: begin
                    d.rd_data = q.irq_tim;
                    d.irq_tim = 8'h00;
                    d.irq_main[MAIN_TIM_PTR] = 1'b0;
                end
                ADDR_IRQ_ERR: begin
                    d.rd_data = q.irq_err;
                    d.irq_err = 8'h00;
                    d.irq_main[MAIN_ERR_PTR] = 1'b0;
                end
                ADDR_FIFO_ST1: d.rd_data = {1'b0, q.cnt};
                ADDR_FIFO_ST2: begin
                    d.rd_data = status2(q);
                    d.lb_incomplete = 1'b0;
                    d.last_byte_valid_bits = 3'h0;
                    d.last_byte_parity_flag = 1'b0;
                    d.ovf = 1'b0;
                    d.unf = 1'b0;
                end
                default: d.rd_data = 8'h00;
            endcase
        end
        // fifo read side
        if (host_rd && q.mode == FIUS_FREAD) begin
            d.rd_data = (q.cnt != 7'h00) ? head : 8'h00;
            if (q.cnt == 7'h00) begin
                d.unf = 1'b1;
            end
        end
        if (fr_tx_req_i) begin
            if (q.cnt != 7'h00) begin
                d.tx_data = head;
                pop = 1'b1;
            end else begin
                d.unf = 1'b1;
            end
        end else if (host_done && q.mode == FIUS_FREAD) begin
            pop = q.cnt != 7'h00;
        end
        // fifo write side
        if (host_wr && q.mode == FIUS_FLOAD) begin
            wr_req = 1'b1;
            mem_wdata = spi_byte_i;
            if (q.loaded != '1) begin
                d.loaded = q.loaded + TX_CNT_W'(1);
            end
        end else if (fr_rx_valid_i) begin
            wr_req = 1'b1;
            mem_wdata = fr_rx_data_i;
        end
        if (wr_req) begin
            if (q.cnt == FIFO_FULL && !pop) begin
                d.ovf = 1'b1;
            end else begin
                push = 1'b1;
                mem_we = 1'b1;
                d.wr_ptr = next_ptr(q.wr_ptr);
            end
        end
        if (pop) begin
            d.rd_ptr = next_ptr(q.rd_ptr);
        end
        d.cnt = q.cnt + {6'h00, push} - {6'h00, pop};
        if (tx_start_i) begin
            d.loaded = '0;
        end
        // water level events
        if (!fifo_busy) begin
            if (tx_active_i && !all_loaded) begin
                if (q.cnt == wl + 7'h01 && d.cnt == wl) begin
                    water_evt = 1'b1;
                end
                if (q.loaded < TX_CNT_W'(wl) && q.cnt == LOW_MARK &&
                    d.cnt == LOW_MARK - 7'h01) begin
                    water_evt = 1'b1;
                end
            end
            if (rx_active_i && q.cnt == wl - 7'h01 && d.cnt == wl) begin
                water_evt = 1'b1;
            end
        end
        if (rx_end_i) begin
            d.lb_incomplete = rx_incomplete_i;
            d.last_byte_valid_bits = rx_valid_bits_i;
            d.last_byte_parity_flag = rx_parity_i;
        end
        // flag sets win over read clears
        d.irq_main = d.irq_main | (main_evt_i & ~PTR_MASK & ~WATER_MASK);
        d.irq_main[MAIN_WATER_BIT] = d.irq_main[MAIN_WATER_BIT] | water_evt;
        d.irq_tim = d.irq_tim | timer_evt_i;
        d.irq_err = d.irq_err | err_evt_i;
        d.irq_main[MAIN_TIM_PTR] = d.irq_main[MAIN_TIM_PTR] | (|timer_evt_i);
        d.irq_main[MAIN_ERR_PTR] = d.irq_main[MAIN_ERR_PTR] | (|err_evt_i);
        if (rx_start_i) begin
            d.wr_ptr = '0;
            d.rd_ptr = '0;
            d.cnt = 7'h00;
            d.lb_incomplete = 1'b0;
            d.last_byte_valid_bits = 3'h0;
            d.last_byte_parity_flag = 1'b0;
            d.ovf = 1'b0;
            d.unf = 1'b0;
        end
        d.irq = pend(d);
    end

    // =========================================================
    // registers and storage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.io_cfg <= IO_CFG_RST;
        end else if (en_i) begin
            q <= d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (en_i && mem_we) begin
            mem_q[mem_waddr] <= mem_wdata;
        end
    end

    fius_clk_out u_clk_out (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(en_i),
        .osc_run_i(osc_run_i),
        .xtal_ref_i(xtal_ref_i),
        .lf_clk_i(lf_clk_i),
        .sel_i(q.io_cfg[CFG_CLK_LSB +: 2]),
        .lf_off_i(q.io_cfg[CFG_LF_OFF]),
        .mcu_clk_o(mcu_clk_o)
    );

    assign spi_rd_data_o = q.rd_data;
    assign fr_tx_data_o = q.tx_data;
    assign irq_o = q.irq;

    // =========================================================
    // checks
    default clocking fius_cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_irq_raise_event: assert property (en_i &&
        |(main_evt_i & ~q.msk_main & ~PTR_MASK & ~WATER_MASK) |=> irq_o)
        else $error("event did not raise request");
    a_main_read_clear: assert property (en_i && host_rd &&
        q.mode == FIUS_RD && q.addr == ADDR_IRQ_MAIN && main_evt_i == 8'h00
        && !water_evt |=> (q.irq_main & ~PTR_MASK) == 8'h00)
        else $error("main flags not cleared by read");
    a_ptr_bit_hold: assert property (en_i && host_rd && q.mode == FIUS_RD
        && q.addr == ADDR_IRQ_MAIN && q.irq_main[MAIN_TIM_PTR]
        |=> q.irq_main[MAIN_TIM_PTR])
        else $error("pointer bit lost on main read");
    a_irq_hold_pend: assert property (pend(q) |-> irq_o)
        else $error("request low while flags pending");
    a_masked_flag_set: assert property (en_i && main_evt_i[5] &&
        q.msk_main[5] |=> q.irq_main[5])
        else $error("masked source did not set flag");
    a_irq_matches: assert property (irq_o == pend(q))
        else $error("request differs from pending flags");
    a_tx_water: assert property (en_i && tx_active_i && !fifo_busy &&
        !all_loaded && fr_tx_req_i && !fr_rx_valid_i && !rx_start_i &&
        q.cnt == wl + 7'h01 |=> q.irq_main[MAIN_WATER_BIT])
        else $error("transmit water event missing");
    a_rx_water: assert property (en_i && rx_active_i && !tx_active_i &&
        !fifo_busy && fr_rx_valid_i && !fr_tx_req_i && !rx_start_i &&
        q.cnt == wl - 7'h01 |=> q.irq_main[MAIN_WATER_BIT])
        else $error("receive water event missing");
    a_no_water_busy: assert property (en_i && fifo_busy &&
        !q.irq_main[MAIN_WATER_BIT] |=> !q.irq_main[MAIN_WATER_BIT])
        else $error("water event during fifo access");
    a_rx_start_clr: assert property (en_i && rx_start_i
        |=> q.cnt == 7'h00 && !q.ovf && !q.unf)
        else $error("reception start did not clear fifo");
    a_fifo_ovf: assert property (en_i && host_wr && q.mode == FIUS_FLOAD
        && q.cnt == FIFO_FULL && !fr_tx_req_i && !rx_start_i
        |=> q.ovf && q.cnt == FIFO_FULL)
        else $error("overflow not flagged");
    a_fifo_unf: assert property (en_i && fr_tx_req_i && q.cnt == 7'h00
        && !rx_start_i |=> q.unf)
        else $error("underflow not flagged");
    a_fread_keep: assert property (en_i && q.mode == FIUS_FREAD && ss_n_i
        && !fr_tx_req_i && !fr_rx_valid_i && !rx_start_i
        |=> q.cnt == $past(q.cnt))
        else $error("partly read byte was consumed");

    c_water: cover property (water_evt);
    c_overflow: cover property (q.ovf);
    c_fifo_read: cover property (host_done && q.mode == FIUS_FREAD);
    c_irq_rise: cover property ($rose(irq_o));

endmodule
`default_nettype wire

// [hw/fius_pkg.sv]
// constants and types shared by the fifo and interrupt status unit
package fius_pkg;

    // =========================================================
    // fifo geometry and water levels
    localparam int FIFO_DEPTH = 96;
    localparam int PTR_W = 7;
    localparam logic [6:0] FIFO_FULL = 7'h60;
    localparam logic [6:0] LOW_MARK = 7'h04;
    localparam logic [6:0] TX_WL_0 = 7'h20;
    localparam logic [6:0] TX_WL_1 = 7'h10;
    localparam logic [6:0] RX_WL_0 = 7'h40;
    localparam logic [6:0] RX_WL_1 = 7'h50;

    // =========================================================
    // register addresses
    localparam logic [5:0] ADDR_IO_CFG1 = 6'h07;
    localparam logic [5:0] ADDR_MASK_MAIN = 6'h12;
    localparam logic [5:0] ADDR_MASK_TIM = 6'h13;
    localparam logic [5:0] ADDR_MASK_ERR = 6'h14;
    localparam logic [5:0] ADDR_IRQ_MAIN = 6'h17;
    localparam logic [5:0] ADDR_IRQ_TIM = 6'h18;
    localparam logic [5:0] ADDR_IRQ_ERR = 6'h19;
    localparam logic [5:0] ADDR_FIFO_ST1 = 6'h1a;
    localparam logic [5:0] ADDR_FIFO_ST2 = 6'h1b;

    // =========================================================
    // command byte coding
    localparam logic [1:0] SPI_REG_WR = 2'b00;
    localparam logic [1:0] SPI_REG_RD = 2'b01;
    localparam logic [1:0] SPI_FIFO = 2'b10;
    localparam logic [5:0] FIFO_LOAD_LOW = 6'h00;
    localparam logic [5:0] FIFO_READ_LOW = 6'h3f;

    // =========================================================
    // field positions and reset values
    localparam int MAIN_WATER_BIT = 6;
    localparam int MAIN_TIM_PTR = 1;
    localparam int MAIN_ERR_PTR = 0;
    localparam logic [7:0] PTR_MASK = 8'h03;
    localparam logic [7:0] WATER_MASK = 8'h40;
    localparam int CFG_CLK_LSB = 6;
    localparam int CFG_LF_OFF = 5;
    localparam int CFG_RX_WL = 1;
    localparam int CFG_TX_WL = 0;
    localparam logic [7:0] IO_CFG_RST = 8'h40;
    localparam int ST2_INCOMPLETE = 6;
    localparam int ST2_UNF = 5;
    localparam int ST2_OVF = 4;
    localparam int ST2_BITS_LSB = 1;
    localparam int ST2_PAR = 0;

    // =========================================================
    // host clock selection
    localparam int CLK_SEL_W = 2;
    localparam logic [1:0] CLK_SEL_OFF = 2'b00;
    localparam logic [1:0] CLK_SEL_DIV4 = 2'b01;
    localparam logic [1:0] CLK_SEL_DIV2 = 2'b10;
    localparam logic [1:0] CLK_SEL_DIV1 = 2'b11;

    typedef enum logic [2:0] {
        FIUS_CMD, FIUS_WR, FIUS_RD, FIUS_FLOAD, FIUS_FREAD, FIUS_SKIP
    } fius_mode_t;

endpackage

// [hw/fius_clk_out.sv]
// host clock output selector and divider
`timescale 1ns/100ps
`default_nettype none
module fius_clk_out (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic osc_run_i,
    input wire logic xtal_ref_i,
    input wire logic lf_clk_i,
    input wire logic [fius_pkg::CLK_SEL_W-1:0] sel_i,
    input wire logic lf_off_i,
    output logic mcu_clk_o
);
    import fius_pkg::*;

    typedef struct packed {
        logic ref_q;
        logic [1:0] div_q;
        logic out_q;
    } fius_clk_state_t;

    fius_clk_state_t q, d;

    // =========================================================
    // divider and selection
    always_comb begin
        d = q;
        d.ref_q = xtal_ref_i;
        if (xtal_ref_i && !q.ref_q) begin
            d.div_q = q.div_q + 2'b01;
        end
        if (osc_run_i) begin
            case (sel_i)
                CLK_SEL_DIV1: d.out_q = xtal_ref_i;
                CLK_SEL_DIV2: d.out_q = q.div_q[0];
                CLK_SEL_DIV4: d.out_q = q.div_q[1];
                default: d.out_q = 1'b0;
            endcase
        end else begin
            d.out_q = lf_off_i ? 1'b0 : lf_clk_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (en_i) begin
            q <= d;
        end
    end

    assign mcu_clk_o = q.out_q;

    // =========================================================
    // checks
    a_slow_clk_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        en_i && !osc_run_i && lf_off_i |=> !mcu_clk_o)
        else $error("slow clock leaks while disabled");
    a_clk_out_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        en_i && osc_run_i && sel_i == CLK_SEL_OFF |=> !mcu_clk_o)
        else $error("host clock driven while off");

endmodule
`default_nettype wire

// [verif/fius_host_model.sv]
// host microcontroller model on the byte side of the serial port
`timescale 1ns/100ps
`default_nettype none
module fius_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    output logic ss_n_o,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic rd_req_o,
    output logic rd_done_o
);
    initial begin
        ss_n_o = 1'b1;
        byte_valid_o = 1'b0;
        byte_o = 8'h00;
        rd_req_o = 1'b0;
        rd_done_o = 1'b0;
    end
    // ====================
    // byte transfers
    task automatic put(input logic [7:0] b);
        @(negedge clk_i);
        byte_valid_o = 1'b1;
        byte_o = b;
        @(negedge clk_i);
        byte_valid_o = 1'b0;
        byte_o = ~b;
    endtask
    task automatic start(input logic [7:0] cmd);
        @(negedge clk_i);
        ss_n_o = 1'b0;
        put(cmd);
    endtask
    task automatic get(output logic [7:0] d, input logic done);
        @(negedge clk_i);
        rd_req_o = 1'b1;
        @(negedge clk_i);
        rd_req_o = 1'b0;
        @(negedge clk_i);
        d = rd_data_i;
        rd_done_o = done;
        @(negedge clk_i);
        rd_done_o = 1'b0;
    endtask
    task automatic finish();
        @(negedge clk_i);
        ss_n_o = 1'b1;
        @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the fifo and interrupt status unit
`timescale 1ns/100ps
`default_nettype none
`define HM fius_host_model_inst
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %0t %h %h", $time, a, e); end end
module tb;
    import fius_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ss_n, bv, rq, dn, irq, mclk;
    logic [7:0] sb, rdat, txd, d;
    logic tx_act = 1'b0, tx_st = 1'b0, txq = 1'b0, rx_act = 1'b0;
    logic rx_st = 1'b0, rxv = 1'b0, rx_end = 1'b0, osc = 1'b0;
    logic xt = 1'b0, lf = 1'b0;
    logic [4:0] lbs = 5'h1b;
    logic [7:0] rxd = 8'h00, mev = 8'h00, tev = 8'h00, eev = 8'h00;
    int fail_count = 0, comparisons = 0, cyc = 0;
    // ====================
    // clock, timeout, instances
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        xt <= ~xt;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    fius_host_model fius_host_model_inst (.clk_i(clk_i), .rd_data_i(rdat),
        .ss_n_o(ss_n), .byte_valid_o(bv), .byte_o(sb), .rd_req_o(rq),
        .rd_done_o(dn));
    fius_top fius_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(1'b1),
        .ss_n_i(ss_n), .spi_byte_valid_i(bv), .spi_byte_i(sb),
        .spi_rd_req_i(rq), .spi_rd_done_i(dn), .spi_rd_data_o(rdat),
        .tx_active_i(tx_act), .tx_start_i(tx_st), .tx_total_i(13'd100),
        .fr_tx_req_i(txq), .fr_tx_data_o(txd), .rx_active_i(rx_act),
        .rx_start_i(rx_st), .fr_rx_valid_i(rxv), .fr_rx_data_i(rxd),
        .rx_end_i(rx_end), .rx_incomplete_i(lbs[4]),
        .rx_valid_bits_i(lbs[3:1]), .rx_parity_i(lbs[0]), .main_evt_i(mev),
        .timer_evt_i(tev), .err_evt_i(eev), .osc_run_i(osc),
        .xtal_ref_i(xt), .lf_clk_i(lf), .irq_o(irq), .mcu_clk_o(mclk));
    // ====================
    // shared tasks
    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask
    task automatic ev(input logic [7:0] m, t, e);
        @(negedge clk_i);
        mev = m;
        tev = t;
        eev = e;
        @(negedge clk_i);
        {mev, tev, eev} = 24'h000000;
    endtask
    task automatic rreg(input logic [5:0] a, input logic [7:0] e);
        `HM.start({SPI_REG_RD, a});
        `HM.get(d, 1'b1);
        `HM.finish();
        `CHK(d, e)
    endtask
    task automatic wreg(input logic [5:0] a, input logic [7:0] v);
        `HM.start({SPI_REG_WR, a});
        `HM.put(v);
        `HM.finish();
    endtask
    task automatic rirq(input logic [7:0] m, t, e);
        `HM.start({SPI_REG_RD, ADDR_IRQ_MAIN});
        `HM.get(d, 1'b1);
        `CHK(d, m)
        `HM.get(d, 1'b1);
        `CHK(d, t)
        `HM.get(d, 1'b1);
        `CHK(d, e)
        `HM.finish();
    endtask
    // ====================
    // scenarios
    task automatic t_irq();
        ev(8'h20, 8'h00, 8'h00);
        `CHK(irq, 1'b1)
        ev(8'h00, 8'h00, 8'h04);
        rirq(8'h21, 8'h00, 8'h04);
        `CHK(irq, 1'b0)
        ev(8'h00, 8'h02, 8'h00);
        rreg(ADDR_IRQ_MAIN, 8'h02);
        rreg(ADDR_IRQ_MAIN, 8'h02);
        `CHK(irq, 1'b1)
        rreg(ADDR_IRQ_TIM, 8'h02);
        `CHK(irq, 1'b0)
        wreg(ADDR_MASK_MAIN, 8'h20);
        ev(8'h20, 8'h00, 8'h00);
        `CHK(irq, 1'b0)
        rirq(8'h20, 8'h00, 8'h00);
        wreg(ADDR_MASK_MAIN, 8'h00);
    endtask
    task automatic t_tx();
        tx_act = 1'b1;
        pulse(tx_st);
        `HM.start({SPI_FIFO, FIFO_LOAD_LOW});
        for (int i = 0; i < 33; i++) `HM.put(8'(i));
        `HM.finish();
        rreg(ADDR_FIFO_ST1, 8'h21);
        pulse(txq);
        `CHK(irq, 1'b1)
        rirq(WATER_MASK, 8'h00, 8'h00);
        for (int i = 1; i < 33; i++) begin
            pulse(txq);
            `CHK(txd, 8'(i))
        end
        `CHK(irq, 1'b0)
        pulse(txq);
        rreg(ADDR_FIFO_ST2, 8'h20);
        wreg(ADDR_IO_CFG1, 8'h41);
        pulse(tx_st);
        `HM.start({SPI_FIFO, FIFO_LOAD_LOW});
        for (int i = 0; i < 5; i++) `HM.put(8'(i));
        `HM.finish();
        pulse(txq);
        `CHK(irq, 1'b0)
        pulse(txq);
        `CHK(txd, 8'h01)
        `CHK(irq, 1'b1)
        rirq(WATER_MASK, 8'h00, 8'h00);
        repeat (3) pulse(txq);
        tx_act = 1'b0;
        `HM.start({SPI_FIFO, FIFO_LOAD_LOW});
        for (int i = 0; i < 97; i++) `HM.put(8'h5a);
        `HM.finish();
        rreg(ADDR_FIFO_ST1, 8'h60);
        rreg(ADDR_FIFO_ST2, 8'h10);
        rreg(ADDR_FIFO_ST2, 8'h00);
    endtask
    task automatic t_rx();
        rx_act = 1'b1;
        pulse(rx_st);
        rreg(ADDR_FIFO_ST1, 8'h00);
        for (int i = 0; i < 64; i++) begin
            rxd = 8'(i);
            pulse(rxv);
            if (i == 62) `CHK(irq, 1'b0)
        end
        rirq(WATER_MASK, 8'h00, 8'h00);
        pulse(rx_end);
        rreg(ADDR_FIFO_ST2, 8'h4b);
        lbs = 5'h04;
        pulse(rx_end);
        rreg(ADDR_FIFO_ST2, 8'h04);
        `HM.start({SPI_FIFO, FIFO_READ_LOW});
        `HM.get(d, 1'b0);
        `HM.finish();
        `HM.start({SPI_FIFO, FIFO_READ_LOW});
        `HM.get(d, 1'b1);
        `CHK(d, 8'h00)
        `HM.get(d, 1'b1);
        `CHK(d, 8'h01)
        `HM.finish();
        rreg(ADDR_FIFO_ST1, 8'h3e);
        rx_act = 1'b0;
    endtask
    task automatic t_clk();
        lf = 1'b1;
        repeat (3) @(negedge clk_i);
        `CHK(mclk, 1'b1)
        wreg(ADDR_IO_CFG1, 8'h60);
        `CHK(mclk, 1'b0)
        osc = 1'b1;
        wreg(ADDR_IO_CFG1, 8'hc0);
        @(negedge clk_i);
        d[0] = mclk;
        @(negedge clk_i);
        `CHK(mclk, ~d[0])
        wreg(ADDR_IO_CFG1, 8'h00);
        `CHK(mclk, 1'b0)
    endtask
    task automatic summarize();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        rreg(ADDR_IO_CFG1, IO_CFG_RST);
        t_irq();
        t_tx();
        t_rx();
        t_clk();
        summarize();
    end
endmodule
`default_nettype wire
